/* File: bench/hbridge_chk.sv */
// Checker on the bridge control top ports.
// Assumes one clock and a synchronous active-low reset.
module hbridge_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_overcurrent_detect,
  input wire logic i_thermal_shutdown_detect,
  input wire logic o_fault_flag_out,
  input wire logic o_fault_flag_oe_n,
  input wire logic o_standby,
  input wire logic o_a_pos_hi,
  input wire logic o_a_pos_lo,
  input wire logic o_a_neg_hi,
  input wire logic o_a_neg_lo,
  input wire logic o_b_pos_hi,
  input wire logic o_b_pos_lo,
  input wire logic o_b_neg_hi,
  input wire logic o_b_neg_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEAD = 80;
  wire  [7:0] gates = {o_a_pos_hi, o_a_pos_lo, o_a_neg_hi, o_a_neg_lo,
                       o_b_pos_hi, o_b_pos_lo, o_b_neg_hi, o_b_neg_lo};
  logic [6:0] lo_idle_r;
  logic [6:0] hi_idle_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Reset turns every gate off, so the dead time is counted from it too
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || o_a_pos_lo) lo_idle_r <= 7'h00;
    else if (lo_idle_r != 7'h7F) lo_idle_r <= lo_idle_r + 7'h01;
    if (!i_rst_n || o_a_pos_hi) hi_idle_r <= 7'h00;
    else if (hi_idle_r != 7'h7F) hi_idle_r <= hi_idle_r + 7'h01;
  end
  sequence fault_held;
    (i_overcurrent_detect || i_thermal_shutdown_detect) [*8];
  endsequence
  sequence calm_standby;
    (o_standby && !i_overcurrent_detect && !i_thermal_shutdown_detect) [*8];
  endsequence
  a_flag_sink_only: assert property (o_fault_flag_out == 1'b0)
    else $error("flag data not low");
  a_fault_sets: assert property (fault_held |-> ##[0:2] !o_fault_flag_oe_n)
    else $error("fault not flagged");
  a_fault_gates_off: assert property (!o_fault_flag_oe_n [*2] |-> gates == 8'h00)
    else $error("gates on in fault");
  a_fault_holds: assert property (
    !o_fault_flag_oe_n && !o_standby |=> !o_fault_flag_oe_n)
    else $error("fault released early");
  a_standby_clears: assert property (calm_standby |=> o_fault_flag_oe_n)
    else $error("fault not cleared");
  a_standby_idle: assert property (o_standby [*2] |-> gates == 8'h00)
    else $error("gates on in standby");
  a_no_shoot: assert property (
    !(o_a_pos_hi && o_a_pos_lo) && !(o_a_neg_hi && o_a_neg_lo))
    else $error("half bridge shorted");
  a_dead_lo_hi: assert property ($rose(o_a_pos_hi) |-> lo_idle_r >= DEAD)
    else $error("dead time short before high side");
  a_dead_hi_lo: assert property ($rose(o_a_pos_lo) |-> hi_idle_r >= DEAD)
    else $error("dead time short before low side");
endmodule

bind hbridge_chop_fault_control hbridge_chk i_chk (.*);

/* File: bench/mcu_model.sv */
// Controller model: drives the six control pins and reads the fault line.
// Assumes an open-drain flag with a pull-up; pins change just after a clock edge.
module mcu_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_flag_data,
  input  wire logic       i_flag_oe_n,
  output logic      [2:0] o_ctl_a,
  output logic      [2:0] o_ctl_b,
  output wire logic       o_fault_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_ctl_a = 3'h0;
  initial o_ctl_b = 3'h0;
  // Released line reads high through the pull-up
  assign o_fault_seen = i_flag_oe_n ? 1'b1 : i_flag_data;
  // Pins are {in1, in2, pwm}; all six low requests standby
  task automatic drive(input logic [2:0] a, input logic [2:0] b);
    @(posedge i_sys_clk);
    o_ctl_a <= a;
    o_ctl_b <= b;
  endtask
endmodule

/* File: bench/tb_hbridge_chop_fault_control.sv */
// Testbench for the dual bridge chopping and fault control.
// Assumes the controller model drives the pins; the bench drives oscillator and sensors.
module tb_hbridge_chop_fault_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       osc = 1'b0;
  logic       trip_a = 1'b0;
  logic       trip_b = 1'b0;
  logic       oc = 1'b0;
  logic       ts = 1'b0;
  logic       pair = 1'b0;
  logic       dir_a = 1'b1;
  logic       dir_b = 1'b0;
  wire  [2:0] ctl_a;
  wire  [2:0] ctl_b;
  wire        flag, flag_oe_n, stby, seen;
  wire  [7:0] g;
  int         n_mismatch = 0;
  int         compares = 0;
  int         ta, tb;
  int         trips[$] = '{1, 9, 10, 13, 16};

  hbridge_chop_fault_control i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_chop_oscillator(osc),
    .i_dir_in1_bridge_a(ctl_a[2]), .i_dir_in2_bridge_a(ctl_a[1]), .i_pwm_in_bridge_a(ctl_a[0]),
    .i_dir_in1_bridge_b(ctl_b[2]), .i_dir_in2_bridge_b(ctl_b[1]), .i_pwm_in_bridge_b(ctl_b[0]),
    .i_bridge_pairing_select(pair), .i_limit_trip_a(trip_a), .i_limit_trip_b(trip_b),
    .i_overcurrent_detect(oc), .i_thermal_shutdown_detect(ts),
    .o_fault_flag_out(flag), .o_fault_flag_oe_n(flag_oe_n), .o_standby(stby),
    .o_a_pos_hi(g[7]), .o_a_pos_lo(g[6]), .o_a_neg_hi(g[5]), .o_a_neg_lo(g[4]),
    .o_b_pos_hi(g[3]), .o_b_pos_lo(g[2]), .o_b_neg_hi(g[1]), .o_b_neg_lo(g[0]));
  mcu_model i_mcu (.i_sys_clk(clk), .i_flag_data(flag), .i_flag_oe_n(flag_oe_n),
    .o_ctl_a(ctl_a), .o_ctl_b(ctl_b), .o_fault_seen(seen));

  initial forever #2.5 clk = ~clk;

  // Gates {pos_hi, pos_lo, neg_hi, neg_lo} at count k, trip from count t;
  // Charge holds until the trip, even past the mixed decay point
  function automatic logic [3:0] model(input logic cw, input int t, input int k, input bit pwm);
    if (!pwm) return 4'h5;
    if (k < t) return cw ? 4'h9 : 4'h6;
    if (k >= 10) return cw ? 4'h6 : 4'h9;
    return 4'h5;
  endfunction

  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic leave();
    i_mcu.drive({dir_a, ~dir_a, 1'b1}, {dir_b, ~dir_b, 1'b1});
    repeat (20) @(posedge clk);
  endtask

  // One oscillator count of 191 cycles; sampled late so dead time has passed
  task automatic tick(input int k, input bit pwm);
    i_mcu.drive({dir_a, ~dir_a, pwm}, {dir_b, ~dir_b, 1'b1});
    osc <= 1'b1;
    repeat (10) @(posedge clk);
    trip_a <= (k >= ta);
    trip_b <= (k >= tb);
    repeat (90) @(posedge clk);
    osc <= 1'b0;
    repeat (90) @(posedge clk);
    #1 check(g, {model(dir_a, ta, k, pwm), model(dir_b, tb, k, 1'b1)});
  endtask

  task automatic period(input int t_a, input int t_b, input int brake_k);
    ta = t_a;
    tb = t_b;
    for (int i = 1; i <= 16; i++) tick(i % 16, i != brake_k);
    $display("period done, trips %0d %0d", ta, tb);
  endtask

  task automatic results();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(14));
    repeat (3) trips.push_back(1 + $urandom % 15);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    leave();
    foreach (trips[i]) period(trips[i], 17 - trips[i], 3);
    for (int f = 0; f < 2; f++) begin
      leave();
      {oc, ts} <= f ? 2'b01 : 2'b10;
      repeat (20) @(posedge clk);
      {oc, ts} <= 2'b00;
      repeat (100) @(posedge clk);
      #1 check(g, 8'h00);
      check({6'h00, stby, seen}, 8'h00);
      i_mcu.drive(3'h0, 3'h0);
      repeat (20) @(posedge clk);
      #1 check({6'h00, stby, seen}, 8'h03);
      $display("fault source %0d done", f);
    end
    @(posedge clk) oc <= 1'b1;
    repeat (20) @(posedge clk);
    {oc, rst_n} <= 2'b00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1 check({7'h00, seen}, 8'h01);
    dir_a = 1'($urandom % 2);
    dir_b = ~dir_a;
    leave();
    period(1 + $urandom % 15, 16, 16);
    period(16, 1 + $urandom % 15, 5);
    // Paired mode is static, so it is changed only under reset
    @(posedge clk) {rst_n, pair} <= 2'b01;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    i_mcu.drive(3'h5, 3'h0);
    repeat (100) @(posedge clk);
    #1 check(g, 8'h99);
    i_mcu.drive(3'h0, 3'h5);
    repeat (20) @(posedge clk);
    #1 check(g, 8'h00);
    check({7'h00, stby}, 8'h01);
    $display("paired bridges done");
    results();
  end

  // Ten periods of about 3100 cycles each, plus fault and pairing steps
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule

/* File: design/half_bridge_gate.v */
// Gate driver for one half-bridge with dead time on every switch-over.
// Assumes a requested state of high-side, low-side or both off, from the same clock.
`include "hbridge_chop_defines.vh"
module half_bridge_gate (
  input  wire i_sys_clk,
  input  wire i_rst_n,
  input  wire i_want_hi,
  input  wire i_want_lo,
  output reg  o_gate_hi,
  output reg  o_gate_lo
);
  reg [`DEAD_CNT_W-1:0]  dead_r;
  wire [31:0]            dead_full = `DEAD_TIME_CYC;
  wire [`DEAD_CNT_W-1:0] dead_load = dead_full[`DEAD_CNT_W-1:0];

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_gate_hi <= 1'b0;
      o_gate_lo <= 1'b0;
      // Reset switches the gates off, so the dead time runs from it as well
      dead_r    <= dead_load; // [R10]
    end else if ((o_gate_hi && !i_want_hi) || (o_gate_lo && !i_want_lo)) begin
      // Turn-off is immediate; the dead time runs after it
      o_gate_hi <= 1'b0;
      o_gate_lo <= 1'b0;
      dead_r    <= dead_load; // [R10]
    end else if (dead_r != `DEAD_CNT_RST) begin
      dead_r <= dead_r - 1'b1; // [R10]
    end else if (!o_gate_hi && !o_gate_lo) begin
      // Never both on, even if asked, to rule out shoot-through
      o_gate_hi <= i_want_hi && !i_want_lo; // [R10]
      o_gate_lo <= i_want_lo && !i_want_hi; // [R10]
    end
  end
endmodule

/* File: design/hbridge_chop_defines.vh */
// Timing and sequencing constants for the dual H-bridge chopping and fault control.
// Assumes a 200 MHz system clock.
`ifndef HBRIDGE_CHOP_DEFINES_VH
`define HBRIDGE_CHOP_DEFINES_VH

`define CLK_PERIOD_PS       5000
`define DEAD_TIME_NS        400
`define DEAD_TIME_CYC       ((`DEAD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DEAD_CNT_W          7
`define CHOP_COUNTS         16
`define CHOP_CNT_W          4
`define MIXED_DECAY_COUNTS  6
`define MIXED_DECAY_POS     (`CHOP_COUNTS - `MIXED_DECAY_COUNTS)
`define BLANK_COUNTS        1
`define CHOP_CNT_RST        4'h0
`define DEAD_CNT_RST        7'h00

`endif

/* File: design/hbridge_chop_fault_control.v */
// Dual H-bridge control: internal mixed-decay chopping, dead time, fault latch and flag.
// Assumes pins are asynchronous to i_sys_clk and oscillator ticks come from the RC oscillator.
//
// How it works
// R1: The fault flag is pulled low once overcurrent or overtemperature has fired, else released.
// R2: The fault flag is open drain: it only sinks low and never drives high.
// R3: The fault stays latched until power-on reset or standby entry, then the flag is released.
// R4: Each chopping period is exactly sixteen oscillator counts.
// R5: Each period runs Charge, then Slow Decay, then Fast Decay, restarting at Charge.
// R6: Charge drives current until the limit comparator trips, then the bridge goes to Slow Decay.
// R7: Six counts before the period end the bridge enters Fast Decay for the rest of the period.
// R8: A trip with fewer than six counts left skips Slow Decay and goes straight to Fast Decay.
// R9: Chopping is asynchronous to external PWM and external input changes apply at once.
// R10: Every switch of output transistors inserts a 400 ns dead time with both off.
// R11: Threshold detection is blanked at the start of Charge and on any direction input change.
// R12: Standby is entered only when all six control inputs are low; in paired mode the code enters it when the three bridge A inputs are low.
// R13: On overcurrent or overtemperature all output transistors go off while the fault is latched.
// R14: Power-on reset clears the fault latch and chop counter; leaving standby starts in Charge.
`include "hbridge_chop_defines.vh"
module hbridge_chop_fault_control (
  input  wire i_sys_clk,
  input  wire i_rst_n,
  input  wire i_chop_oscillator,
  input  wire i_dir_in1_bridge_a,
  input  wire i_dir_in2_bridge_a,
  input  wire i_pwm_in_bridge_a,
  input  wire i_dir_in1_bridge_b,
  input  wire i_dir_in2_bridge_b,
  input  wire i_pwm_in_bridge_b,
  input  wire i_bridge_pairing_select,
  input  wire i_limit_trip_a,
  input  wire i_limit_trip_b,
  input  wire i_overcurrent_detect,
  input  wire i_thermal_shutdown_detect,
  output wire o_fault_flag_out,
  output wire o_fault_flag_oe_n,
  output wire o_standby,
  output wire o_a_pos_hi,
  output wire o_a_pos_lo,
  output wire o_a_neg_hi,
  output wire o_a_neg_lo,
  output wire o_b_pos_hi,
  output wire o_b_pos_lo,
  output wire o_b_neg_hi,
  output wire o_b_neg_lo
);
  localparam [2:0] PH_CHARGE = 3'b001;
  localparam [2:0] PH_SLOW   = 3'b010;
  localparam [2:0] PH_FAST   = 3'b100;

  wire       osc_s;
  wire [5:0] ctl_s;
  wire       pair_s;
  wire       trip_a_s;
  wire       trip_b_s;
  wire       ocd_s;
  wire       tsd_s;

  // Every input pin except i_rst_n gets its own synchroniser; only the reset reaches the logic raw
  input_sync u_sync_osc (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_chop_oscillator),
    .o_level   (osc_s)
  );
  input_sync u_sync_in1_a (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_dir_in1_bridge_a),
    .o_level   (ctl_s[5])
  );
  input_sync u_sync_in2_a (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_dir_in2_bridge_a),
    .o_level   (ctl_s[4])
  );
  input_sync u_sync_pwm_a (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_pwm_in_bridge_a),
    .o_level   (ctl_s[3])
  );
  input_sync u_sync_in1_b (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_dir_in1_bridge_b),
    .o_level   (ctl_s[2])
  );
  input_sync u_sync_in2_b (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_dir_in2_bridge_b),
    .o_level   (ctl_s[1])
  );
  input_sync u_sync_pwm_b (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_pwm_in_bridge_b),
    .o_level   (ctl_s[0])
  );
  input_sync u_sync_pair (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_bridge_pairing_select),
    .o_level   (pair_s)
  );
  input_sync u_sync_trip_a (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_limit_trip_a),
    .o_level   (trip_a_s)
  );
  input_sync u_sync_trip_b (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_limit_trip_b),
    .o_level   (trip_b_s)
  );
  input_sync u_sync_ocd (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_overcurrent_detect),
    .o_level   (ocd_s)
  );
  input_sync u_sync_tsd (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_thermal_shutdown_detect),
    .o_level   (tsd_s)
  );

  genvar gi;

  // Single-bridge pairing steers bridge B from the bridge A inputs
  wire in1_a = ctl_s[5];
  wire in2_a = ctl_s[4];
  wire pwm_a = ctl_s[3];
  wire in1_b = pair_s ? ctl_s[5] : ctl_s[2];
  wire in2_b = pair_s ? ctl_s[4] : ctl_s[1];
  wire pwm_b = pair_s ? ctl_s[3] : ctl_s[0];
  wire all_low = (pair_s ? (ctl_s[5:3] == 3'h0) : (ctl_s == 6'h00));
  wire standby = all_low; // [R12]
  assign o_standby = standby;

  // Oscillator edge gives one tick per oscillator count
  reg osc_d_r;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_s;
    end
  end
  wire osc_tick = osc_s && !osc_d_r;

  // Counter-width copies of the period constants, cut on purpose
  wire [31:0]            cnt_last_full = `CHOP_COUNTS - 1;
  wire [31:0]            mix_pos_full  = `MIXED_DECAY_POS;
  wire [`CHOP_CNT_W-1:0] cnt_last      = cnt_last_full[`CHOP_CNT_W-1:0];
  wire [`CHOP_CNT_W-1:0] mix_pos       = mix_pos_full[`CHOP_CNT_W-1:0];
  wire [`CHOP_CNT_W-1:0] mix_pre       = mix_pos - 1'b1;

  reg                   fault_r;
  reg [`CHOP_CNT_W-1:0] chop_cnt_r;
  wire                  period_end = osc_tick && (chop_cnt_r == cnt_last);

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_r <= 1'b0; // [R14]
    end else if (ocd_s || tsd_s) begin
      fault_r <= 1'b1; // [R1]
    end else if (standby) begin
      fault_r <= 1'b0; // [R3]
    end
  end
  // Open drain: data is fixed low, the enable alone decides the level
  assign o_fault_flag_out  = 1'b0; // [R2]
  assign o_fault_flag_oe_n = !fault_r; // [R1] [R3]

  // Counter held at zero in standby so the first period after wake starts clean
  always @(posedge i_sys_clk) begin
    if (!i_rst_n || standby) begin
      chop_cnt_r <= `CHOP_CNT_RST; // [R14]
    end else if (osc_tick) begin
      chop_cnt_r <= chop_cnt_r + 1'b1; // [R4]
    end
  end

  // Direction change detect for blanking, on the bridge-local inputs
  reg [1:0] dir_a_d_r;
  reg [1:0] dir_b_d_r;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dir_a_d_r <= 2'b00;
      dir_b_d_r <= 2'b00;
    end else begin
      dir_a_d_r <= {in1_a, in2_a};
      dir_b_d_r <= {in1_b, in2_b};
    end
  end
  wire dir_chg = (dir_a_d_r != {in1_a, in2_a}) || (dir_b_d_r != {in1_b, in2_b});

  wire [2:0] phase_a;
  wire [2:0] phase_b;
  wire [1:0] trip_v = {trip_b_s, trip_a_s};
  wire [5:0] phase_cat;

  // Both bridges share the counter; each has its own phase and blanking
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_phase
      reg  [2:0] ph_r;
      reg  [2:0] ph_nxt;
      reg        blank_r;
      reg        blank_cnt_r;
      wire       trip = trip_v[gi] && !blank_r && !dir_chg; // [R11]
      always @* begin
        ph_nxt = ph_r;
        case (ph_r)
          PH_CHARGE: begin
            if (trip) begin
              if (chop_cnt_r >= mix_pos) begin
                ph_nxt = PH_FAST; // [R8]
              end else begin
                ph_nxt = PH_SLOW; // [R6]
              end
            end
          end
          PH_SLOW: begin
            if (osc_tick && chop_cnt_r == mix_pre) begin
              ph_nxt = PH_FAST; // [R7]
            end
          end
          PH_FAST: ph_nxt = PH_FAST;
          default: ph_nxt = PH_CHARGE;
        endcase
        if (period_end) begin
          ph_nxt = PH_CHARGE; // [R5]
        end
      end
      assign phase_cat[gi*3 +: 3] = ph_r;
      always @(posedge i_sys_clk) begin
        if (!i_rst_n || standby) begin
          ph_r        <= PH_CHARGE; // [R14]
          blank_r     <= 1'b1;
          blank_cnt_r <= 1'b0;
        end else begin
          ph_r <= ph_nxt;
          // Every period opens a Charge, even one that never tripped, so blank on each
          if (period_end || dir_chg) begin
            blank_r     <= 1'b1; // [R11]
            blank_cnt_r <= 1'b0;
          end else if (blank_r && osc_tick) begin
            if (blank_cnt_r == 1'b1 || `BLANK_COUNTS == 1) begin
              blank_r <= 1'b0;
            end
            blank_cnt_r <= 1'b1;
          end
        end
      end
    end
  endgenerate
  assign phase_a = phase_cat[2:0];
  assign phase_b = phase_cat[5:3];

  // Drive decode: external inputs combine directly, so a change acts without
  // waiting for the chopping phase; the chopper only shapes forward/reverse drive.
  reg [3:0] want_a;
  reg [3:0] want_b;
  function [3:0] bridge_want;
    input       in1;
    input       in2;
    input       pwm;
    input [2:0] ph;
    begin
      bridge_want = 4'h0; // {pos_hi,pos_lo,neg_hi,neg_lo}; both off = Hi-Z
      if (in1 && in2) begin
        bridge_want = 4'h5; // brake
      end else if (in1 || in2) begin
        if (!pwm) begin
          bridge_want = 4'h5; // brake
        end else if (ph == PH_SLOW) begin
          bridge_want = 4'h5; // [R6] slow decay through low sides
        end else if (ph == PH_FAST) begin
          bridge_want = in1 ? 4'h6 : 4'h9; // [R7] reversed drive returns current
        end else begin
          bridge_want = in1 ? 4'h9 : 4'h6; // [R6] charge
        end
      end
    end
  endfunction

  always @* begin
    want_a = bridge_want(in1_a, in2_a, pwm_a, phase_a); // [R9]
    want_b = bridge_want(in1_b, in2_b, pwm_b, phase_b); // [R9]
    if (fault_r || standby) begin
      want_a = 4'h0; // [R13]
      want_b = 4'h0; // [R13]
    end
  end

  wire [7:0] want_v = {want_b, want_a};
  wire [7:0] gate_v;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_gate
      half_bridge_gate u_gate (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_want_hi (want_v[gi*2+1]),
        .i_want_lo (want_v[gi*2]),
        .o_gate_hi (gate_v[gi*2+1]),
        .o_gate_lo (gate_v[gi*2])
      );
    end
  endgenerate

  assign o_a_pos_hi = gate_v[3];
  assign o_a_pos_lo = gate_v[2];
  assign o_a_neg_hi = gate_v[1];
  assign o_a_neg_lo = gate_v[0];
  assign o_b_pos_hi = gate_v[7];
  assign o_b_pos_lo = gate_v[6];
  assign o_b_neg_hi = gate_v[5];
  assign o_b_neg_lo = gate_v[4];
endmodule

/* File: design/input_sync.v */
// Three-flop synchroniser for one asynchronous pin.
// Assumes the input is unrelated to i_sys_clk; output moves when stages two and three agree.
module input_sync (
  input  wire i_sys_clk,
  input  wire i_rst_n,
  input  wire i_async,
  output reg  o_level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end
endmodule
